// file: design/link_frame_rx.sv
`timescale 1ns/1ps
`default_nettype none
module link_frame_rx #(
  parameter int unsigned BIT_CYCLES = link_port_pkg::BIT_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              line_in,
  output var  link_port_pkg::rx_evt_t evt
);

  link_port_pkg::rx_state_t state_r, state_nxt;
  link_port_pkg::cnt_t      tmr_r, tmr_nxt;
  logic [3:0]               cnt_r, cnt_nxt;
  logic [15:0]              sh_r, sh_nxt;
  logic                     par_r, par_nxt;
  link_port_pkg::rx_evt_t   evt_r, evt_nxt;

  always_comb
  begin
    state_nxt    = state_r;
    tmr_nxt      = tmr_r;
    cnt_nxt      = cnt_r;
    sh_nxt       = sh_r;
    par_nxt      = par_r;
    evt_nxt      = evt_r;
    evt_nxt.done = 1'b0;
    case (state_r)
      link_port_pkg::RX_IDLE:
        if (!line_in)
        begin
          // Sample mid-bit from here on
          state_nxt = link_port_pkg::RX_START;
          tmr_nxt   = link_port_pkg::cnt_t'(BIT_CYCLES / 2);
        end
      link_port_pkg::RX_START:
        if (tmr_r != '0)
          tmr_nxt = tmr_r - 1'b1;
        else if (line_in)
          state_nxt = link_port_pkg::RX_IDLE;
        else
        begin
          state_nxt = link_port_pkg::RX_DATA;
          tmr_nxt   = link_port_pkg::cnt_t'(BIT_CYCLES - 1);
          cnt_nxt   = 4'h0;
        end
      link_port_pkg::RX_DATA:
        if (tmr_r != '0)
          tmr_nxt = tmr_r - 1'b1;
        else
        begin
          sh_nxt  = {line_in, sh_r[15:1]};
          tmr_nxt = link_port_pkg::cnt_t'(BIT_CYCLES - 1);
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r == 4'hf)
            state_nxt = link_port_pkg::RX_PAR;
        end
      link_port_pkg::RX_PAR:
        if (tmr_r != '0)
          tmr_nxt = tmr_r - 1'b1;
        else
        begin
          par_nxt   = line_in;
          tmr_nxt   = link_port_pkg::cnt_t'(BIT_CYCLES - 1);
          state_nxt = link_port_pkg::RX_STOP;
        end
      link_port_pkg::RX_STOP:
        if (tmr_r != '0)
          tmr_nxt = tmr_r - 1'b1;
        else
        begin
          // Even parity plus high stop bit marks a clean frame
          evt_nxt.done = 1'b1;
          evt_nxt.bad  = !line_in || ((^sh_r) != par_r);
          evt_nxt.word = sh_r;
          state_nxt    = link_port_pkg::RX_IDLE;
        end
      default:
        state_nxt = link_port_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= link_port_pkg::RX_IDLE;
      tmr_r   <= '0;
      cnt_r   <= 4'h0;
      sh_r    <= 16'h0000;
      par_r   <= 1'b0;
      evt_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      tmr_r   <= tmr_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      par_r   <= par_nxt;
      evt_r   <= evt_nxt;
    end
  end

  assign evt = evt_r;

  chk_done_pulse : assert property (@(posedge pclk) disable iff (!presetn)
    evt_r.done |=> !evt_r.done)
    else $error("frame done held longer than one cycle");

endmodule : link_frame_rx
`default_nettype wire

// file: design/link_port_pkg.sv
package link_port_pkg;

  // Clock and link timing, printed figures in ns
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned XFER_TYP_NS   = 19_200_000;
  localparam int unsigned XFER_MAX_NS   = 31_000_000;
  localparam int unsigned MIN_INPUT_NS  = 16_000_000;

  // Frame: start, 16 data, parity, stop, one idle gap bit
  localparam int unsigned FRAME_BITS    = 20;
  localparam int unsigned WORD_BITS     = 16;
  localparam int unsigned CNT_W         = 22;

  // One frame per typical transfer time
  localparam int unsigned BIT_CYC       =
    XFER_TYP_NS / CLK_PERIOD_NS / FRAME_BITS;
  localparam int unsigned XFER_MAX_CYC  = XFER_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned MIN_INPUT_CYC =
    (MIN_INPUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_IN     = 8'h0c;
  localparam logic [7:0] OFS_OUT    = 8'h10;
  localparam logic [7:0] OFS_STATE  = 8'h14;

  // Field positions
  localparam int unsigned CTRL_OUT_VAR = 0;
  localparam int unsigned ST_FRAME     = 0;
  localparam int unsigned ST_ERR       = 1;
  localparam int unsigned ST_RECOV     = 2;
  localparam int unsigned ST_SENT      = 3;
  localparam int unsigned ST_W         = 4;
  localparam int unsigned STATE_ERR    = 0;
  localparam int unsigned STATE_MODE   = 1;
  localparam int unsigned ERR_BIT      = 15;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [3:0]  MASK_RST = 4'h0;
  localparam logic [15:0] OUT_RST  = 16'h0000;

  typedef logic [CNT_W-1:0] cnt_t;

  typedef struct packed {
    logic        done;
    logic        bad;
    logic [15:0] word;
  } rx_evt_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE, TX_SEND
  } tx_state_t;

endpackage : link_port_pkg

// file: design/remote_io_word_link_port.sv
`timescale 1ns/1ps
`default_nettype none
module remote_io_word_link_port #(
  parameter int unsigned BIT_CYCLES  = link_port_pkg::BIT_CYC,
  parameter int unsigned MAX_CYCLES  = link_port_pkg::XFER_MAX_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        mode_sel,
  input  wire logic        link_signal_wire_in,
  output var  logic        link_signal_wire_out,
  output var  logic        link_signal_wire_oe,
  output var  logic [15:0] io_lamp,
  output var  logic        err_lamp,
  output var  logic        irq
);

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == link_port_pkg::OFS_CTRL)   ||
              (a == link_port_pkg::OFS_STATUS) ||
              (a == link_port_pkg::OFS_MASK)   ||
              (a == link_port_pkg::OFS_IN)     ||
              (a == link_port_pkg::OFS_OUT)    ||
              (a == link_port_pkg::OFS_STATE);
  endfunction : reg_hit

  // Upper selector trades input 15 for the error flag
  function automatic logic [15:0] map_word(input logic [15:0] raw,
                                           input logic        err,
                                           input logic        upper);
    map_word = upper ? {err, raw[14:0]} : raw;
  endfunction : map_word

  link_port_pkg::rx_evt_t rx_evt;

  link_frame_rx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_rx (
    .pclk    (pclk),
    .presetn (presetn),
    .line_in (link_signal_wire_in),
    .evt     (rx_evt)
  );

  // Bus-side state
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [3:0]  status_r, status_nxt;
  logic [3:0]  mask_r, mask_nxt;
  logic [15:0] out_word_r, out_word_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        irq_r, irq_nxt;

  // Link-side state
  logic                     mode_r, mode_nxt;
  logic                     err_r, err_nxt;
  logic [15:0]              raw_r, raw_nxt;
  link_port_pkg::cnt_t      wdog_r, wdog_nxt;
  link_port_pkg::tx_state_t tx_r, tx_nxt;
  logic [19:0]              tx_sh_r, tx_sh_nxt;
  link_port_pkg::cnt_t      tx_tmr_r, tx_tmr_nxt;
  logic [4:0]               tx_cnt_r, tx_cnt_nxt;
  logic                     wire_out_r, wire_out_nxt;
  logic                     wire_oe_r, wire_oe_nxt;
  logic [15:0]              lamp_r, lamp_nxt;
  logic                     err_lamp_r, err_lamp_nxt;

  logic       out_var;
  logic       wr_en;
  logic [3:0] ev;

  assign out_var = ctrl_r[link_port_pkg::CTRL_OUT_VAR];
  assign wr_en   = psel && penable && pready_r && pwrite;

  always_comb
  begin
    ctrl_nxt     = ctrl_r;
    mask_nxt     = mask_r;
    out_word_nxt = out_word_r;
    prdata_nxt   = prdata_r;
    pready_nxt   = psel && !penable;
    pslverr_nxt  = psel && !penable && !reg_hit(paddr);
    if (wr_en)
    begin
      case (paddr)
        link_port_pkg::OFS_CTRL: ctrl_nxt     = pwdata;
        link_port_pkg::OFS_MASK: mask_nxt     = pwdata[3:0];
        link_port_pkg::OFS_OUT:  out_word_nxt = pwdata[15:0];
        default:                 ctrl_nxt     = ctrl_r;
      endcase
    end
    // A new event beats a write-one clear in the same cycle
    status_nxt = status_r | ev;
    if (wr_en && paddr == link_port_pkg::OFS_STATUS)
      status_nxt = (status_r & ~pwdata[3:0]) | ev;
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        link_port_pkg::OFS_CTRL:   prdata_nxt = ctrl_r;
        link_port_pkg::OFS_STATUS: prdata_nxt = {28'h0, status_r};
        link_port_pkg::OFS_MASK:   prdata_nxt = {28'h0, mask_r};
        link_port_pkg::OFS_IN:
          prdata_nxt = {16'h0, map_word(raw_r, err_r, mode_r)};
        link_port_pkg::OFS_OUT:    prdata_nxt = {16'h0, out_word_r};
        link_port_pkg::OFS_STATE:  prdata_nxt = {30'h0, mode_r, err_r};
        default:                   prdata_nxt = 32'h0000_0000;
      endcase
    end
    irq_nxt = |(status_nxt & mask_nxt);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r     <= link_port_pkg::CTRL_RST;
      status_r   <= 4'h0;
      mask_r     <= link_port_pkg::MASK_RST;
      out_word_r <= link_port_pkg::OUT_RST;
      prdata_r   <= 32'h0000_0000;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      irq_r      <= 1'b0;
    end
    else
    begin
      ctrl_r     <= ctrl_nxt;
      status_r   <= status_nxt;
      mask_r     <= mask_nxt;
      out_word_r <= out_word_nxt;
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
      irq_r      <= irq_nxt;
    end
  end

  always_comb
  begin
    ev           = 4'h0;
    mode_nxt     = mode_sel;
    err_nxt      = err_r;
    raw_nxt      = raw_r;
    wdog_nxt     = wdog_r;
    tx_nxt       = tx_r;
    tx_sh_nxt    = tx_sh_r;
    tx_tmr_nxt   = tx_tmr_r;
    tx_cnt_nxt   = tx_cnt_r;
    if (out_var)
    begin
      // No receiver checks on the output path
      err_nxt  = 1'b0;
      wdog_nxt = '0;
      case (tx_r)
        link_port_pkg::TX_IDLE:
        begin
          // Gap, stop, even parity, data LSB first, start
          tx_sh_nxt  = {1'b1, 1'b1, ^out_word_r, out_word_r, 1'b0};
          tx_tmr_nxt = link_port_pkg::cnt_t'(BIT_CYCLES - 1);
          tx_cnt_nxt = 5'd0;
          tx_nxt     = link_port_pkg::TX_SEND;
        end
        link_port_pkg::TX_SEND:
          if (tx_tmr_r != '0)
            tx_tmr_nxt = tx_tmr_r - 1'b1;
          else if (tx_cnt_r == 5'(link_port_pkg::FRAME_BITS - 1))
          begin
            ev[link_port_pkg::ST_SENT] = 1'b1;
            tx_nxt = link_port_pkg::TX_IDLE;
          end
          else
          begin
            tx_sh_nxt  = {1'b1, tx_sh_r[19:1]};
            tx_tmr_nxt = link_port_pkg::cnt_t'(BIT_CYCLES - 1);
            tx_cnt_nxt = tx_cnt_r + 5'd1;
          end
        default:
          tx_nxt = link_port_pkg::TX_IDLE;
      endcase
    end
    else
    begin
      tx_nxt    = link_port_pkg::TX_IDLE;
      tx_sh_nxt = 20'hfffff;
      // Silent link past the worst-case delay counts as an error
      if (wdog_r != link_port_pkg::cnt_t'(MAX_CYCLES))
        wdog_nxt = wdog_r + 1'b1;
      else
        err_nxt = 1'b1;
      if (rx_evt.done && rx_evt.bad)
        err_nxt = 1'b1;
      else if (rx_evt.done)
      begin
        // Last good word stays until the next clean frame
        err_nxt  = 1'b0;
        raw_nxt  = rx_evt.word;
        wdog_nxt = '0;
        ev[link_port_pkg::ST_FRAME] = 1'b1;
      end
      ev[link_port_pkg::ST_ERR]   = err_nxt && !err_r;
      ev[link_port_pkg::ST_RECOV] = !err_nxt && err_r;
    end
    wire_out_nxt = tx_sh_nxt[0];
    wire_oe_nxt  = out_var;
    if (out_var)
      lamp_nxt = out_word_r;
    else if (mode_nxt)
      lamp_nxt = {1'b0, raw_nxt[14:0]};
    else
      lamp_nxt = raw_nxt;
    err_lamp_nxt = err_nxt && !out_var;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r     <= 1'b0;
      err_r      <= 1'b0;
      raw_r      <= 16'h0000;
      wdog_r     <= '0;
      tx_r       <= link_port_pkg::TX_IDLE;
      tx_sh_r    <= 20'hfffff;
      tx_tmr_r   <= '0;
      tx_cnt_r   <= 5'd0;
      wire_out_r <= 1'b1;
      wire_oe_r  <= 1'b0;
      lamp_r     <= 16'h0000;
      err_lamp_r <= 1'b0;
    end
    else
    begin
      mode_r     <= mode_nxt;
      err_r      <= err_nxt;
      raw_r      <= raw_nxt;
      wdog_r     <= wdog_nxt;
      tx_r       <= tx_nxt;
      tx_sh_r    <= tx_sh_nxt;
      tx_tmr_r   <= tx_tmr_nxt;
      tx_cnt_r   <= tx_cnt_nxt;
      wire_out_r <= wire_out_nxt;
      wire_oe_r  <= wire_oe_nxt;
      lamp_r     <= lamp_nxt;
      err_lamp_r <= err_lamp_nxt;
    end
  end

  assign prdata               = prdata_r;
  assign pready               = pready_r;
  assign pslverr              = pslverr_r;
  assign link_signal_wire_out = wire_out_r;
  assign link_signal_wire_oe  = wire_oe_r;
  assign io_lamp              = lamp_r;
  assign err_lamp             = err_lamp_r;
  assign irq                  = irq_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_good_frame;
    rx_evt.done && !rx_evt.bad && !out_var;
  endsequence

  sequence s_bad_frame;
    rx_evt.done && rx_evt.bad && !out_var;
  endsequence

  chk_err_bit_map : assert property (
    psel && !penable && !pwrite && paddr == link_port_pkg::OFS_IN &&
    mode_r && !out_var |=> prdata[15] == $past(err_r))
    else $error("bit 15 does not show link error");

  chk_full_word : assert property (
    s_good_frame ##1 (!mode_r && !out_var) |-> io_lamp == raw_r)
    else $error("16-point lamps differ from received word");

  chk_low_bits : assert property (
    s_good_frame |=> !out_var |-> raw_r[14:0] == $past(rx_evt.word[14:0]))
    else $error("bits 00-14 not taken from frame");

  chk_bad_lights : assert property (
    s_bad_frame |=> err_lamp)
    else $error("error lamp not lit after bad frame");

  chk_clear_next : assert property (
    err_r ##0 s_good_frame |=> !err_lamp && !err_r)
    else $error("error lamp not cleared by good cycle");

  chk_out_no_err : assert property (
    out_var |=> !err_r)
    else $error("output variant reported a link error");

  chk_max_delay : assert property (
    (!out_var && wdog_r == link_port_pkg::cnt_t'(MAX_CYCLES)) |=> err_r
      || $past(rx_evt.done))
    else $error("silent link not flagged after worst-case delay");

  chk_lamp15_unused : assert property (
    (mode_sel && !out_var) |=> !io_lamp[15])
    else $error("lamp 15 lit in error-bit mode");

  chk_out_lamps : assert property (
    out_var |=> io_lamp == $past(out_word_r))
    else $error("output lamps differ from output word");

  chk_err_lamp_only_in : assert property (
    out_var |=> !err_lamp)
    else $error("error lamp lit on output variant");

  chk_strap_follow : assert property (
    1'b1 |=> mode_r == $past(mode_sel))
    else $error("selector not sampled every cycle");

endmodule : remote_io_word_link_port
`default_nettype wire

// file: dv/remote_terminal.sv
`timescale 1ns/1ps
`default_nettype none
module remote_terminal #(
  parameter int unsigned BIT_CYCLES = 8
) (
  input  wire logic pclk,
  input  wire logic line_rx,
  input  wire logic rx_en,
  output var  logic line_tx
);
  logic [15:0] held_word;
  logic [15:0] got_word;
  int          got_count;

  initial
  begin
    line_tx   = 1'b1;
    held_word = 16'h0000;
    got_word  = 16'h0000;
    got_count = 0;
  end

  // Start, 16 data bits LSB first, even parity, stop
  task send_word(input logic [15:0] w, input logic bad);
    logic [18:0] f;
    f = {1'b1, ^w ^ bad, w, 1'b0};
    @(posedge pclk);
    for (int i = 0; i < 19; i++)
    begin
      line_tx <= f[i];
      repeat (BIT_CYCLES) @(posedge pclk);
    end
    if (!bad)
      held_word = w;
  endtask : send_word

  // On an error the last good word is sent again
  task send_held;
    send_word(held_word, 1'b0);
  endtask : send_held

  // First frame after power returns carries zero
  task power_up;
    held_word = 16'h0000;
    send_word(16'h0000, 1'b0);
  endtask : power_up

  // Receive side, only while the port drives the line
  always
  begin
    logic [15:0] w;
    logic        p;
    @(posedge pclk);
    if (rx_en && !line_rx)
    begin
      repeat (BIT_CYCLES / 2) @(posedge pclk);
      for (int i = 0; i < 16; i++)
      begin
        repeat (BIT_CYCLES) @(posedge pclk);
        w[i] = line_rx;
      end
      repeat (BIT_CYCLES) @(posedge pclk);
      p = line_rx;
      repeat (BIT_CYCLES) @(posedge pclk);
      if (line_rx && p == ^w)
      begin
        got_word = w;
        got_count++;
      end
    end
  end
endmodule : remote_terminal
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned BIT_CYC = 8;
  localparam int unsigned MAX_CYC = 400;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        mode_sel;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        serr;
  logic        wire_out;
  logic        wire_oe;
  logic        err_lamp;
  logic        irq;
  logic        term_tx;
  logic        line;
  logic [15:0] io_lamp;
  int          err_count;
  int          n_compared;
  int          c0;

  // Port drive wins while enabled, terminal otherwise
  assign line = wire_oe ? wire_out : term_tx;

  remote_io_word_link_port #(
    .BIT_CYCLES (BIT_CYC),
    .MAX_CYCLES (MAX_CYC)
  ) DUT (
    .pclk                 (pclk),
    .presetn              (presetn),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .mode_sel             (mode_sel),
    .link_signal_wire_in  (line),
    .link_signal_wire_out (wire_out),
    .link_signal_wire_oe  (wire_oe),
    .io_lamp              (io_lamp),
    .err_lamp             (err_lamp),
    .irq                  (irq)
  );

  remote_terminal #(
    .BIT_CYCLES (BIT_CYC)
  ) term (
    .pclk    (pclk),
    .line_rx (line),
    .rx_en   (wire_oe),
    .line_tx (term_tx)
  );

  always #5 pclk = ~pclk;

  task wrap_up;
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the slave; only the bench timeout ends a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd      = prdata;
    serr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rchk

  initial
  begin
    #80_000;
    err_count++;
    wrap_up();
  end

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    mode_sel = 1'b0;
    err_count = 0;
    n_compared = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk({12'h000, io_lamp, err_lamp, irq, wire_oe, wire_out}, 32'h1);
    rchk(link_port_pkg::OFS_CTRL, link_port_pkg::CTRL_RST);
    rchk(link_port_pkg::OFS_MASK, {28'h0, link_port_pkg::MASK_RST});
    rchk(link_port_pkg::OFS_OUT, {16'h0, link_port_pkg::OUT_RST});
    rchk(link_port_pkg::OFS_STATUS, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({rd[30:0], serr}, 32'h0000_0001);
    // Sixteen inputs
    term.send_word(16'ha5c3, 1'b0);
    repeat (3) @(posedge pclk);
    chk({16'h0, io_lamp}, 32'h0000_a5c3);
    rchk(link_port_pkg::OFS_IN, 32'h0000_a5c3);
    chk({31'h0, irq}, 32'h0); // Frame event is masked
    // Fifteen inputs plus error bit
    mode_sel <= 1'b1;
    term.send_word(16'hd2b4, 1'b0);
    repeat (3) @(posedge pclk);
    chk({16'h0, io_lamp}, 32'h0000_52b4);
    rchk(link_port_pkg::OFS_IN, 32'h0000_52b4);
    apb(1'b1, link_port_pkg::OFS_MASK, 32'h0000_0002);
    term.send_word(16'h0f0f, 1'b1);
    repeat (3) @(posedge pclk);
    chk({31'h0, err_lamp}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rchk(link_port_pkg::OFS_IN, 32'h0000_d2b4);
    rchk(link_port_pkg::OFS_STATE, 32'h0000_0003);
    apb(1'b1, link_port_pkg::OFS_STATUS, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    term.send_held();
    repeat (3) @(posedge pclk);
    chk({31'h0, err_lamp}, 32'h0);
    rchk(link_port_pkg::OFS_IN, 32'h0000_52b4);
    mode_sel <= 1'b0;
    repeat (2) @(posedge pclk);
    rchk(link_port_pkg::OFS_IN, 32'h0000_d2b4);
    apb(1'b1, link_port_pkg::OFS_STATUS, 32'h0000_000f);
    // Terminal silent past the longest transfer time
    repeat (MAX_CYC - 100) @(posedge pclk);
    chk({31'h0, err_lamp}, 32'h0);
    repeat (150) @(posedge pclk);
    chk({31'h0, err_lamp}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rchk(link_port_pkg::OFS_STATE, 32'h0000_0001);
    term.power_up();
    repeat (3) @(posedge pclk);
    chk({31'h0, err_lamp}, 32'h0);
    rchk(link_port_pkg::OFS_IN, 32'h0000_0000);
    apb(1'b0, link_port_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rd & 32'h4, 32'h4);
    // Output variant, word held for two received frames
    apb(1'b1, link_port_pkg::OFS_CTRL, 32'h0000_0001);
    apb(1'b1, link_port_pkg::OFS_OUT, 32'h0000_1234);
    apb(1'b1, link_port_pkg::OFS_IN, 32'h0000_ffff);
    rchk(link_port_pkg::OFS_IN, 32'h0000_0000);
    rchk(link_port_pkg::OFS_OUT, 32'h0000_1234);
    c0 = term.got_count;
    repeat (2000)
      if (term.got_count < c0 + 2)
        @(posedge pclk);
    chk({16'h0, term.got_word}, 32'h0000_1234);
    chk({16'h0, io_lamp}, 32'h0000_1234);
    chk({31'h0, wire_oe}, 32'h1);
    apb(1'b0, link_port_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rd & 32'h8, 32'h8);
    repeat (MAX_CYC + 50) @(posedge pclk);
    chk({31'h0, err_lamp}, 32'h0);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
